// ---- rtl/prs_oneshot.sv ----
module prs_oneshot #(
  parameter int unsigned CYCLES = 62500
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_busy
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic busy_ff;

  // Retrigger restarts the full delay
  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_start) begin
      nxt_cnt = CNT_LOAD;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CNT_ONE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_ff <= CNT_LOAD;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      busy_ff <= 1'b1;
    end else begin
      busy_ff <= (nxt_cnt != '0);
    end
  end

  assign o_busy = busy_ff;

endmodule

// ---- rtl/prs_pkg.sv ----
package prs_pkg;

  localparam int unsigned PRS_PADDR_W = 8;
  localparam int unsigned PRS_IDX_SHIFT = 2;
  localparam int unsigned PRS_IDX_W = PRS_PADDR_W - PRS_IDX_SHIFT;

  // Register indices; byte address is index times four
  localparam logic [PRS_IDX_W-1:0] PRS_SEL_ONE_IDX = 6'h0C;
  localparam logic [PRS_IDX_W-1:0] PRS_SEL_TWO_IDX = 6'h0D;
  localparam logic [PRS_IDX_W-1:0] PRS_CTRL_IDX = 6'h0E;
  localparam logic [PRS_IDX_W-1:0] PRS_STATUS_IDX = 6'h0F;

  localparam int unsigned PRS_SRC_LSB = 2;
  localparam int unsigned PRS_SRC_MSB = 4;
  localparam int unsigned PRS_POR_EN_BIT = 5;
  localparam int unsigned PRS_LEVEL_BIT = 6;
  localparam int unsigned PRS_CTRL_HALT_BIT = 0;
  localparam int unsigned PRS_CTRL_STOP_BIT = 1;
  localparam logic [7:0] PRS_SEL_ONE_WMASK = 8'h7C;
  localparam logic [7:0] PRS_SEL_TWO_WMASK = 8'h5C;
  localparam logic [7:0] PRS_SEL_RST = 8'h00;
  localparam logic [31:0] PRS_RDATA_ZERO = 32'h0000_0000;

  localparam logic [15:0] PRS_RESTART_ADDR = 16'h000C;

  localparam longint unsigned PRS_POR_TIME_NS = 2_500_000;
  localparam longint unsigned PRS_CLK_PERIOD_NS = 40;
  localparam int unsigned PRS_POR_CYCLES =
    int'((PRS_POR_TIME_NS + PRS_CLK_PERIOD_NS - 1) / PRS_CLK_PERIOD_NS);

  // Pin vector layout: port0 [7:0], port2 [15:8], port3 [23:16]
  localparam logic [23:0] PRS_MASK_P2_LO = 24'h000F00;
  localparam logic [23:0] PRS_MASK_P2_ALL = 24'h00FF00;
  localparam logic [23:0] PRS_MASK_P3 = 24'h0E0000;
  localparam logic [23:0] PRS_MASK_P3_P0 = 24'h0E0081;
  localparam logic [23:0] PRS_MASK_P3_P2 = 24'h0E0700;
  localparam logic [23:0] PRS_MASK_NONE = 24'h000000;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_P2_LO_NAND = 3'b001,
    SRC_P2_ALL_NAND = 3'b010,
    SRC_P3_NOR = 3'b011,
    SRC_P3_NAND = 3'b100,
    SRC_P3_P0_NOR = 3'b101,
    SRC_P3_P0_NAND = 3'b110,
    SRC_P3_P2_NAND = 3'b111
  } prs_src_t;

  typedef struct packed {
    logic level;
    prs_src_t src;
  } prs_rec_cfg_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_STOP = 3'b011,
    ST_XRST = 3'b100
  } prs_state_t;

  typedef enum logic [1:0] {
    CAUSE_POR = 2'b00,
    CAUSE_WDT = 2'b01,
    CAUSE_REC = 2'b10,
    CAUSE_EXT = 2'b11
  } prs_cause_t;

  typedef struct packed {
    logic power_good;
    prs_cause_t cause;
    logic timer_busy;
    prs_state_t state;
  } prs_status_t;

  function automatic logic prs_rec_event(input prs_rec_cfg_t cfg, input logic [23:0] pins,
                                         input logic [23:0] pin_out);
    logic [23:0] mask;
    logic nor_sel;
    logic term;
    mask = PRS_MASK_NONE;
    nor_sel = 1'b0;
    case (cfg.src)
      SRC_P2_LO_NAND: mask = PRS_MASK_P2_LO;
      SRC_P2_ALL_NAND: mask = PRS_MASK_P2_ALL;
      SRC_P3_NOR: begin
        mask = PRS_MASK_P3;
        nor_sel = 1'b1;
      end
      SRC_P3_NAND: mask = PRS_MASK_P3;
      SRC_P3_P0_NOR: begin
        mask = PRS_MASK_P3_P0;
        nor_sel = 1'b1;
      end
      SRC_P3_P0_NAND: mask = PRS_MASK_P3_P0;
      SRC_P3_P2_NAND: mask = PRS_MASK_P3_P2;
      default: mask = PRS_MASK_NONE;
    endcase
    mask = mask & ~pin_out;
    if (nor_sel) begin
      term = ~|(pins & mask);
    end else begin
      term = ~&(pins | ~mask);
    end
    return (cfg.src != SRC_NONE) && (term ^ cfg.level);
  endfunction

endpackage

// ---- rtl/prs_power_seq.sv ----
module prs_power_seq
  import prs_pkg::*;
#(
  parameter int unsigned POR_CYCLES = PRS_POR_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [PRS_PADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_power_good,
  input wire logic i_watchdog_timeout,
  input wire logic i_ext_reset,
  input wire logic [7:0] i_port0,
  input wire logic [7:0] i_port2,
  input wire logic [7:0] i_port3,
  input wire logic [7:0] i_port0_is_out,
  input wire logic [7:0] i_port2_is_out,
  input wire logic [7:0] i_port3_is_out,
  input wire logic [5:0] i_irq_pending,
  output logic o_cpu_reset,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_crystal_oscillator_en,
  output logic o_halted,
  output logic [15:0] o_restart_addr
);

  function automatic logic reg_hit(input logic [PRS_PADDR_W-1:0] addr,
                                   input logic [PRS_IDX_W-1:0] idx);
    return addr == {idx, 2'b00};
  endfunction

  prs_state_t state_ff;
  prs_state_t nxt_state;
  prs_cause_t cause_ff;
  logic [7:0] sel_one_ff;
  prs_rec_cfg_t sel_two_ff;
  logic pg_prev_ff;
  logic rec_ev_ff;
  logic timer_busy;
  logic por_trig;
  logic rec_por;
  logic timer_start;
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic cmd_halt;
  logic cmd_stop;
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic cpu_reset_ff;
  logic cpu_clk_en_ff;
  logic periph_clk_en_ff;
  logic crystal_oscillator_en_ff;
  logic halted_ff;
  logic [15:0] restart_addr_ff;
  logic [23:0] pins;
  logic [23:0] pins_out;
  prs_rec_cfg_t sel_one_cfg;
  prs_status_t status;

  assign pins = {i_port3, i_port2, i_port0};
  assign pins_out = {i_port3_is_out, i_port2_is_out, i_port0_is_out};
  assign sel_one_cfg = {sel_one_ff[PRS_LEVEL_BIT],
                        prs_src_t'(sel_one_ff[PRS_SRC_MSB:PRS_SRC_LSB])};
  assign status = {i_power_good, cause_ff, timer_busy, state_ff};

  // APB slave, one wait-free access phase
  assign apb_setup = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable & pready_ff;
  assign apb_wr = apb_access & i_pwrite;
  assign cmd_halt = apb_wr & reg_hit(i_paddr, PRS_CTRL_IDX) & i_pwdata[PRS_CTRL_HALT_BIT];
  assign cmd_stop = apb_wr & reg_hit(i_paddr, PRS_CTRL_IDX) & i_pwdata[PRS_CTRL_STOP_BIT];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= apb_setup;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prdata_ff <= PRS_RDATA_ZERO;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      prdata_ff <= PRS_RDATA_ZERO;
      pslverr_ff <= 1'b0;
      if (reg_hit(i_paddr, PRS_SEL_ONE_IDX)) begin
        prdata_ff <= {24'h000000, sel_one_ff};
      end else if (reg_hit(i_paddr, PRS_STATUS_IDX)) begin
        prdata_ff <= {25'h0000000, status};
      end else if (!reg_hit(i_paddr, PRS_SEL_TWO_IDX) && !reg_hit(i_paddr, PRS_CTRL_IDX)) begin
        pslverr_ff <= 1'b1;
      end
    end
  end

  // Reserved bits are dropped on write
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sel_one_ff <= PRS_SEL_RST;
    end else if (apb_wr && reg_hit(i_paddr, PRS_SEL_ONE_IDX)) begin
      sel_one_ff <= i_pwdata[7:0] & PRS_SEL_ONE_WMASK;
    end
  end

  // Write-only; reads return zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sel_two_ff <= {PRS_SEL_RST[PRS_LEVEL_BIT],
                     prs_src_t'(PRS_SEL_RST[PRS_SRC_MSB:PRS_SRC_LSB])};
    end else if (apb_wr && reg_hit(i_paddr, PRS_SEL_TWO_IDX)) begin
      sel_two_ff <= {i_pwdata[PRS_LEVEL_BIT],
                     prs_src_t'(i_pwdata[PRS_SRC_MSB:PRS_SRC_LSB])};
    end
  end

  // Either selector wakes; output pins masked inside the term
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rec_ev_ff <= 1'b0;
    end else begin
      rec_ev_ff <= prs_rec_event(sel_one_cfg, pins, pins_out)
                   | prs_rec_event(sel_two_ff, pins, pins_out);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pg_prev_ff <= 1'b0;
    end else begin
      pg_prev_ff <= i_power_good;
    end
  end

  // Brown-out wake shows up as the same power-good rise
  assign por_trig = i_power_good & ~pg_prev_ff;
  assign rec_por = (state_ff == ST_STOP) & rec_ev_ff & sel_one_ff[PRS_POR_EN_BIT];
  assign timer_start = por_trig | i_watchdog_timeout | rec_por;

  // Timer runs on the reference clock, which never stops with the crystal
  prs_oneshot #(
    .CYCLES(POR_CYCLES)
  ) u_oneshot (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(timer_start),
    .o_busy(timer_busy)
  );

  always_comb begin
    nxt_state = state_ff;
    if (!i_power_good || timer_start) begin
      nxt_state = ST_RESET;
    end else if (i_ext_reset) begin
      nxt_state = ST_XRST;
    end else begin
      case (state_ff)
        ST_RESET: begin
          if (!timer_busy) begin
            nxt_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (cmd_stop) begin
            nxt_state = ST_STOP;
          end else if (cmd_halt) begin
            nxt_state = ST_HALT;
          end
        end
        ST_HALT: begin
          if (|i_irq_pending) begin
            nxt_state = ST_RUN;
          end
        end
        ST_STOP: begin
          if (rec_ev_ff) begin
            nxt_state = ST_XRST;
          end
        end
        ST_XRST: nxt_state = ST_RUN;
        default: nxt_state = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cause_ff <= CAUSE_POR;
    end else if (!i_power_good || por_trig) begin
      cause_ff <= CAUSE_POR;
    end else if (i_watchdog_timeout) begin
      cause_ff <= CAUSE_WDT;
    end else if (state_ff == ST_STOP && rec_ev_ff) begin
      cause_ff <= CAUSE_REC;
    end else if (i_ext_reset) begin
      cause_ff <= CAUSE_EXT;
    end
  end

  // Outputs follow the next state so they line up with it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cpu_reset_ff <= 1'b1;
    end else begin
      cpu_reset_ff <= (nxt_state == ST_RESET) || (nxt_state == ST_XRST);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cpu_clk_en_ff <= 1'b0;
    end else begin
      cpu_clk_en_ff <= (nxt_state == ST_RUN);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      crystal_oscillator_en_ff <= 1'b1;
      periph_clk_en_ff <= 1'b1;
    end else begin
      crystal_oscillator_en_ff <= (nxt_state != ST_STOP);
      periph_clk_en_ff <= (nxt_state != ST_STOP);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      halted_ff <= 1'b0;
    end else begin
      halted_ff <= (nxt_state == ST_HALT) || (nxt_state == ST_STOP);
    end
  end

  // Every reset exit starts at the same vector
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      restart_addr_ff <= PRS_RESTART_ADDR;
    end else begin
      restart_addr_ff <= PRS_RESTART_ADDR;
    end
  end

  assign o_pready = pready_ff;
  assign o_prdata = prdata_ff;
  assign o_pslverr = pslverr_ff;
  assign o_cpu_reset = cpu_reset_ff;
  assign o_cpu_clk_en = cpu_clk_en_ff;
  assign o_periph_clk_en = periph_clk_en_ff;
  assign o_crystal_oscillator_en = crystal_oscillator_en_ff;
  assign o_halted = halted_ff;
  assign o_restart_addr = restart_addr_ff;

  // Cycles since last timer start, saturating
  logic [31:0] len_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || timer_start) begin
      len_ff <= 32'h0000_0000;
    end else if (len_ff < POR_CYCLES) begin
      len_ff <= len_ff + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  por_length_a: assert property (
    state_ff == ST_RESET && nxt_state == ST_RUN |-> len_ff >= POR_CYCLES)
    else $error("reset released before the delay expired");

  reset_held_a: assert property (
    state_ff == ST_RESET ##1 state_ff == ST_RESET |-> o_cpu_reset && !o_cpu_clk_en)
    else $error("processor not held in reset during delay");

  halt_clocks_a: assert property (
    state_ff == ST_HALT |-> !o_cpu_clk_en && o_crystal_oscillator_en)
    else $error("halt clock gating wrong");

  halt_periph_a: assert property (
    state_ff == ST_HALT |-> o_periph_clk_en)
    else $error("peripherals stopped in halt");

  halt_exit_a: assert property (
    state_ff == ST_HALT && i_power_good && !timer_start && !i_ext_reset
    |=> (state_ff == ST_RUN) == $past(|i_irq_pending))
    else $error("halt exit not tied to interrupt");

  stop_clocks_a: assert property (
    state_ff == ST_STOP |-> !o_crystal_oscillator_en && !o_cpu_clk_en)
    else $error("clocks running in stop");

  stop_exit_a: assert property (
    state_ff == ST_STOP ##1 state_ff != ST_STOP
    |-> (state_ff == ST_RESET || state_ff == ST_XRST) && o_cpu_reset)
    else $error("stop left without reset");

  rec_path_a: assert property (
    state_ff == ST_STOP && rec_ev_ff && i_power_good && !i_watchdog_timeout && !i_ext_reset
    |=> state_ff == (sel_one_ff[PRS_POR_EN_BIT] ? ST_RESET : ST_XRST))
    else $error("recovery delay select ignored");

  sel_two_wo_a: assert property (
    apb_setup && reg_hit(i_paddr, PRS_SEL_TWO_IDX) |=> o_prdata == PRS_RDATA_ZERO && !o_pslverr)
    else $error("write-only register readable");

  src_none_a: assert property (
    sel_two_ff.src == SRC_NONE && sel_one_ff[PRS_SRC_MSB:PRS_SRC_LSB] == 3'h0 |=> !rec_ev_ff)
    else $error("recovery event with no source");

  halt_cycle_c: cover property (
    state_ff == ST_RUN ##1 state_ff == ST_HALT ##[1:50] state_ff == ST_RUN);
  stop_bypass_c: cover property (state_ff == ST_STOP ##1 state_ff == ST_XRST);
  stop_delay_c: cover property (state_ff == ST_STOP ##1 state_ff == ST_RESET);
  wdt_reset_c: cover property (state_ff == ST_RUN && i_watchdog_timeout);

endmodule

// ---- tb/tb_prs_power_seq.sv ----
module tb_prs_power_seq;
  timeunit 1ns;
  timeprecision 1ps;
  import prs_pkg::*;

  localparam int POR = 20;

  typedef struct packed {
    logic chk;
    logic [31:0] d;
    logic err;
  } prs_exp_t;

  logic i_ref_clk, i_rst, i_psel, i_penable, i_pwrite;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata;
  logic o_pready, o_pslverr, o_cpu_reset, o_cpu_clk_en, o_periph_clk_en;
  logic o_crystal_oscillator_en, o_halted;
  logic [31:0] o_prdata;
  logic [15:0] o_restart_addr;
  logic i_power_good, i_watchdog_timeout, i_ext_reset;
  logic [23:0] pins, outs, r;
  logic [5:0] i_irq_pending;
  prs_exp_t exp_q[$];
  prs_exp_t e;
  int fail_count, samples_checked, seed, c, k, n;

  prs_power_seq #(.POR_CYCLES(POR)) i_prs_power_seq (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_power_good(i_power_good),
    .i_watchdog_timeout(i_watchdog_timeout), .i_ext_reset(i_ext_reset),
    .i_port0(pins[7:0]), .i_port2(pins[15:8]), .i_port3(pins[23:16]),
    .i_port0_is_out(outs[7:0]), .i_port2_is_out(outs[15:8]), .i_port3_is_out(outs[23:16]),
    .i_irq_pending(i_irq_pending), .o_cpu_reset(o_cpu_reset), .o_cpu_clk_en(o_cpu_clk_en),
    .o_periph_clk_en(o_periph_clk_en), .o_crystal_oscillator_en(o_crystal_oscillator_en),
    .o_halted(o_halted), .o_restart_addr(o_restart_addr)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_range(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic timeout;
    fail_count++;
    $display("mismatch at %0t: got %h expected %h (wait ran out)", $time, 0, 1);
    close_out();
  endtask

  // Ends one edge after completion so back-to-back calls never reassign in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic chk, input logic [31:0] ed, input logic ee);
    int j;
    exp_q.push_back('{chk, ed, ee});
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    for (j = 0; j < 20; j++) begin
      @(posedge i_ref_clk);
      if (o_pready === 1'b1) break;
    end
    if (j == 20) timeout();
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  always @(posedge i_ref_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        timeout();
      end else begin
        e = exp_q.pop_front();
        if (e.chk) cmp_val(o_prdata, e.d);
        cmp_val({31'h0, o_pslverr}, {31'h0, e.err});
      end
    end
  end

  // Counts edges until the processor reset shows the wanted level
  task automatic wait_rst(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (o_cpu_reset !== lvl) begin
      @(posedge i_ref_clk);
      cnt++;
      if (cnt > lim) timeout();
    end
  endtask

  function automatic logic [23:0] msk(input int code);
    case (code)
      1: return 24'h000F00;
      2: return 24'h00FF00;
      3, 4: return 24'h0E0000;
      5, 6: return 24'h0E0081;
      7: return 24'h0E0700;
      default: return 24'h000000;
    endcase
  endfunction

  task automatic stop_cycle(input logic [7:0] s1, input logic [7:0] s2, input logic [23:0] idle,
                            input logic [23:0] wake, input int lo, input int hi);
    int m;
    pins <= idle;
    apb(1'b1, 8'h30, {24'h0, s1}, 1'b0, 32'h0, 1'b0);
    apb(1'b1, 8'h34, {24'h0, s2}, 1'b0, 32'h0, 1'b0);
    apb(1'b1, 8'h38, 32'h2, 1'b0, 32'h0, 1'b0);
    cmp_val({28'h0, o_crystal_oscillator_en, o_periph_clk_en, o_cpu_clk_en, o_halted},
            32'h1);
    repeat (4) @(posedge i_ref_clk);
    cmp_val({30'h0, o_halted, o_cpu_reset}, 32'h2);
    pins <= wake;
    wait_rst(1'b1, 10, m);
    wait_rst(1'b0, POR + 10, m);
    cmp_range(m, lo, hi);
    cmp_val({o_restart_addr, 15'h0, o_cpu_clk_en}, 32'h000C_0001);
    pins <= idle;
    @(posedge i_ref_clk);
  endtask

  initial begin
    seed = 1116;
    fail_count = 0;
    samples_checked = 0;
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_power_good = 1'b1;
    i_watchdog_timeout = 1'b0;
    i_ext_reset = 1'b0;
    pins = 24'hFFFFFF;
    outs = 24'h000000;
    i_irq_pending = 6'h00;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    wait_rst(1'b0, POR + 10, n);
    cmp_range(n, POR, POR + 3);
    apb(1'b1, 8'h30, 32'h7C, 1'b0, 32'h0, 1'b0);
    apb(1'b0, 8'h30, 32'h0, 1'b1, 32'h7C, 1'b0);
    apb(1'b1, 8'h34, 32'h5C, 1'b0, 32'h0, 1'b0);
    apb(1'b0, 8'h34, 32'h0, 1'b1, 32'h0, 1'b0);
    apb(1'b0, 8'h80, 32'h0, 1'b1, 32'h0, 1'b1);
    apb(1'b1, 8'h31, 32'h1, 1'b0, 32'h0, 1'b1);
    apb(1'b0, 8'h3C, 32'h0, 1'b1, 32'h41, 1'b0);
    for (c = 0; c < 6; c++) begin
      apb(1'b1, 8'h38, 32'h1, 1'b0, 32'h0, 1'b0);
      cmp_val({28'h0, o_crystal_oscillator_en, o_periph_clk_en, o_cpu_clk_en, o_halted},
              32'hD);
      i_irq_pending <= 6'h01 << c;
      for (k = 0; k < 10 && o_halted !== 1'b0; k++) @(posedge i_ref_clk);
      if (k == 10) timeout();
      cmp_val({31'h0, o_cpu_clk_en}, 32'h1);
      i_irq_pending <= 6'h00;
      @(posedge i_ref_clk);
    end
    for (c = 1; c < 8; c++) begin
      r = 24'($random(seed));
      stop_cycle(8'h00, {3'b000, c[2:0], 2'b00}, r | msk(c), r & ~msk(c), 1, 1);
    end
    r = 24'($random(seed));
    stop_cycle(8'h00, 8'h50, r & ~msk(4), r | msk(4), 1, 1);
    stop_cycle(8'h0C, 8'h00, r | msk(3), r & ~msk(3), 1, 1);
    outs <= 24'h000100;
    stop_cycle(8'h00, 8'h04, (r | 24'h000E00) & ~24'h000100, r & ~msk(1), 1, 1);
    outs <= 24'h000000;
    stop_cycle(8'h24, 8'h00, r | msk(1), r & ~msk(1), POR, POR + 3);
    // External reset ends stop with no delay; status shows the external cause
    apb(1'b1, 8'h38, 32'h2, 1'b0, 32'h0, 1'b0);
    i_ext_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_ext_reset <= 1'b0;
    wait_rst(1'b1, 5, n);
    wait_rst(1'b0, 5, n);
    cmp_range(n, 1, 1);
    apb(1'b0, 8'h3C, 32'h0, 1'b1, 32'h71, 1'b0);
    i_watchdog_timeout <= 1'b1;
    @(posedge i_ref_clk);
    i_watchdog_timeout <= 1'b0;
    wait_rst(1'b1, 5, n);
    wait_rst(1'b0, POR + 10, n);
    cmp_range(n, POR - 1, POR + 3);
    i_power_good <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_power_good <= 1'b1;
    wait_rst(1'b0, POR + 10, n);
    cmp_range(n, POR, POR + 3);
    close_out();
  end
endmodule
